// ### core/pwm_carrier_pkg.sv
// Register map, field positions and constants of the PWM/carrier timer
package pwm_carrier_pkg;
  localparam int CNT_W = 8;
  localparam int CKS_W = 3;
  localparam logic [7:0] MODE_OFS = 8'h00;
  localparam logic [7:0] CYCLE_OFS = 8'h04;
  localparam logic [7:0] DUTY_OFS = 8'h08;
  localparam logic [7:0] CARRIER_OFS = 8'h0C;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam int MODE_EN_BIT = 0;
  localparam int MODE_CARRIER_BIT = 1;
  localparam int MODE_CKS_LSB = 2;
  localparam int MODE_LEV_BIT = 5;
  localparam int CAR_BUF_BIT = 0;
  localparam int CAR_ACT_BIT = 1;
  localparam int CAR_RMC_BIT = 2;
  localparam logic [7:0] COMPARE_RESET = 8'h00;
  localparam logic [1:0] DUTY_SETTLE = 2'h3;
  typedef enum logic {CMP_FIRST, CMP_SECOND} cmp_phase_e;
endpackage : pwm_carrier_pkg

// ### core/count_clock_prescaler.sv
// Count clock prescaler: one-cycle enable pulse at clk divided by 2**sel
`timescale 1ns/100ps
`default_nettype none
module count_clock_prescaler #(
  parameter int SEL_W = 3
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic run,
  input wire logic [SEL_W-1:0] sel,
  output logic tick
);
  localparam int DIV_W = (1 << SEL_W) - 1;

  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic tick;
  } presc_s;

  presc_s q;
  presc_s next_q;
  logic [DIV_W-1:0] mask;

  always_comb begin
    mask = DIV_W'((1 << sel) - 1);
    next_q = q;
    next_q.tick = 1'b0;
    // Divider restarts with the run so the first tick is a full period away
    if (!run) begin
      next_q.div = '0;
    end else begin
      next_q.tick = ((q.div & mask) == mask);
      next_q.div = q.div + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign tick = q.tick;
endmodule : count_clock_prescaler
`default_nettype wire

// ### core/pwm_carrier_timer.sv
// PWM / infrared carrier generator timer with APB register access
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module pwm_carrier_timer #(
  parameter bit CARRIER_CAPABLE = 1'b1,
  parameter int CNT_W = pwm_carrier_pkg::CNT_W
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic gate_counter_match,
  output logic timer_output_pin,
  output logic timer_match_irq,
  output logic synced_transfer_strobe
);
  typedef struct packed {
    logic count_enable_bit;
    logic carrier;
    logic [pwm_carrier_pkg::CKS_W-1:0] clock_select_field;
    logic output_level_select;
    logic [CNT_W-1:0] cycle_compare;
    logic [CNT_W-1:0] duty_compare;
    logic [CNT_W-1:0] duty_latch;
    logic lat_pend;
    logic [1:0] age;
    logic output_enable_buffer;
    logic output_enable_active;
    logic remote_control_enable;
    logic run;
    logic mask;
    logic [CNT_W-1:0] cnt;
    pwm_carrier_pkg::cmp_phase_e phase;
    logic level;
    logic carrier_clk;
    logic gate;
    logic irq;
    logic pin;
    logic [2:0] sy;
    logic gm;
    logic evt_pend;
    logic strobe;
    logic arm;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } timer_s;

  timer_s q;
  timer_s next_q;
  logic tick;
  logic setup;
  logic wr;
  logic [CNT_W-1:0] cmp_val;
  logic match;
  logic settled;
  logic nc;

  count_clock_prescaler #(
    .SEL_W(pwm_carrier_pkg::CKS_W)
  ) u_prescaler (
    .clk(clk),
    .resetn(resetn),
    .run(q.run),
    .sel(q.clock_select_field),
    .tick(tick)
  );

  always_comb begin
    next_q = q;
    setup = psel && !penable;
    wr = psel && penable && q.pready && pwrite;
    next_q.irq = 1'b0;
    next_q.pready = 1'b0;
    next_q.pslverr = 1'b0;
    // first compare is low width / cycle, second is high width / duty
    cmp_val = (q.phase == pwm_carrier_pkg::CMP_FIRST) ? q.cycle_compare : q.duty_compare;
    match = (q.cnt == cmp_val);
    settled = q.lat_pend && (q.age == pwm_carrier_pkg::DUTY_SETTLE);

    // pin synchroniser, a change counts once the last two flops agree
    next_q.sy = {q.sy[1:0], gate_counter_match};
    if (q.sy[1] == q.sy[2]) begin
      next_q.gm = q.sy[2];
    end

    // everything below advances only on count clocks while running
    if (q.run && tick) begin
      if (q.age != pwm_carrier_pkg::DUTY_SETTLE) begin
        next_q.age = q.age + 2'h1;
      end
      // copy lands on the second tick after the strobe rises
      if (q.arm) begin
        next_q.output_enable_active = q.output_enable_buffer;
        next_q.arm = 1'b0;
      end
      if (q.strobe) begin
        next_q.strobe = 1'b0;
        next_q.arm = 1'b1;
      end
      // strobe is one count clock wide and feeds no interrupt
      if (q.evt_pend) begin
        next_q.strobe = 1'b1;
        next_q.evt_pend = 1'b0;
      end
      if (q.mask) begin
        // first count clock after enable is swallowed
        next_q.mask = 1'b0;
      end else if (q.carrier) begin
        if (match) begin
          // clear, interrupt and swap compare on every match
          // restart from zero gives N+1 and M+1 widths
          next_q.cnt = '0;
          next_q.irq = 1'b1;
          // carrier clock inverts on every match
          next_q.carrier_clk = !q.carrier_clk;
          next_q.phase = (q.phase == pwm_carrier_pkg::CMP_FIRST) ?
                         pwm_carrier_pkg::CMP_SECOND : pwm_carrier_pkg::CMP_FIRST;
        end else begin
          next_q.cnt = q.cnt + 1'b1;
        end
      end else if (match && q.phase == pwm_carrier_pkg::CMP_FIRST) begin
        // cycle match clears, drives active, raises interrupt
        next_q.cnt = '0;
        next_q.irq = 1'b1;
        next_q.level = 1'b1;
        next_q.phase = pwm_carrier_pkg::CMP_SECOND;
      end else begin
        next_q.cnt = q.cnt + 1'b1;
        // duty match only ends the active level
        if (match) begin
          next_q.level = 1'b0;
          next_q.phase = pwm_carrier_pkg::CMP_FIRST;
        end
      end
      // an early match keeps the old duty, the latch waits
      if (!q.mask && match && q.phase == pwm_carrier_pkg::CMP_SECOND && settled) begin
        next_q.duty_compare = q.duty_latch;
        next_q.lat_pend = 1'b0;
      end
    end

    // Event set after the tick clear so a coincident event is not lost
    if (q.sy[1] == q.sy[2] && q.sy[2] && !q.gm) begin
      next_q.evt_pend = 1'b1;
    end

    // stopping drops the interrupt and returns to the inactive level
    next_q.run = q.count_enable_bit;
    if (!q.count_enable_bit || !q.run) begin
      next_q.cnt = '0;
      next_q.level = 1'b0;
      // A match in the stopping cycle must not leak an interrupt
      next_q.irq = 1'b0;
      // restart from the low width compare with the carrier low
      next_q.phase = pwm_carrier_pkg::CMP_FIRST;
      next_q.carrier_clk = 1'b0;
      next_q.mask = q.count_enable_bit;
    end

    if (wr) begin
      case (paddr)
        pwm_carrier_pkg::MODE_OFS: begin
          next_q.count_enable_bit = pwdata[pwm_carrier_pkg::MODE_EN_BIT];
          next_q.carrier = pwdata[pwm_carrier_pkg::MODE_CARRIER_BIT] && CARRIER_CAPABLE;
          next_q.clock_select_field =
            pwdata[pwm_carrier_pkg::MODE_CKS_LSB +: pwm_carrier_pkg::CKS_W];
          next_q.output_level_select = pwdata[pwm_carrier_pkg::MODE_LEV_BIT];
        end
        pwm_carrier_pkg::CYCLE_OFS: begin
          next_q.cycle_compare = pwdata[CNT_W-1:0];
        end
        pwm_carrier_pkg::DUTY_OFS: begin
          // while running the write only reaches the holding latch
          if (q.run) begin
            next_q.duty_latch = pwdata[CNT_W-1:0];
            next_q.lat_pend = 1'b1;
            next_q.age = 2'h0;
          end else begin
            next_q.duty_compare = pwdata[CNT_W-1:0];
            next_q.lat_pend = 1'b0;
          end
        end
        pwm_carrier_pkg::CARRIER_OFS: begin
          // the buffer and remote control bits are writable, the active bit is not
          next_q.output_enable_buffer = pwdata[pwm_carrier_pkg::CAR_BUF_BIT];
          next_q.remote_control_enable = pwdata[pwm_carrier_pkg::CAR_RMC_BIT];
        end
        default: begin
        end
      endcase
    end

    // Read data is captured in the setup cycle, so no wait states
    if (setup) begin
      next_q.pready = 1'b1;
      next_q.pslverr = 1'b0;
      next_q.prdata = '0;
      case (paddr)
        pwm_carrier_pkg::MODE_OFS: begin
          next_q.prdata[pwm_carrier_pkg::MODE_EN_BIT] = q.count_enable_bit;
          next_q.prdata[pwm_carrier_pkg::MODE_CARRIER_BIT] = q.carrier;
          next_q.prdata[pwm_carrier_pkg::MODE_CKS_LSB +: pwm_carrier_pkg::CKS_W] =
            q.clock_select_field;
          next_q.prdata[pwm_carrier_pkg::MODE_LEV_BIT] = q.output_level_select;
        end
        pwm_carrier_pkg::CYCLE_OFS: begin
          next_q.prdata[CNT_W-1:0] = q.cycle_compare;
        end
        pwm_carrier_pkg::DUTY_OFS: begin
          next_q.prdata[CNT_W-1:0] = q.lat_pend ? q.duty_latch : q.duty_compare;
        end
        pwm_carrier_pkg::CARRIER_OFS: begin
          next_q.prdata[pwm_carrier_pkg::CAR_BUF_BIT] = q.output_enable_buffer;
          next_q.prdata[pwm_carrier_pkg::CAR_ACT_BIT] = q.output_enable_active;
          next_q.prdata[pwm_carrier_pkg::CAR_RMC_BIT] = q.remote_control_enable;
        end
        pwm_carrier_pkg::STATUS_OFS: begin
          next_q.prdata[CNT_W-1:0] = q.cnt;
          next_q.prdata[CNT_W +: CNT_W] = q.duty_compare;
          next_q.prdata[16] = q.carrier_clk;
          next_q.prdata[17] = (q.phase == pwm_carrier_pkg::CMP_SECOND);
          next_q.prdata[18] = q.lat_pend;
          next_q.prdata[19] = q.run;
        end
        default: begin
          next_q.pslverr = 1'b1;
        end
      endcase
    end

    // gate opens only on a rising carrier edge with the enable active
    nc = next_q.carrier_clk;
    if (nc && !q.carrier_clk && next_q.output_enable_active) begin
      next_q.gate = 1'b1;
    end else if (!nc && !next_q.output_enable_active) begin
      // gate closes only once the carrier is low again
      next_q.gate = 1'b0;
    end
    // output selection, carrier only through the gate
    if (!q.carrier) begin
      next_q.pin = next_q.level ^ q.output_level_select;
    end else if (!q.remote_control_enable) begin
      next_q.pin = next_q.output_enable_active;
    end else begin
      next_q.pin = next_q.gate && nc;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign timer_output_pin = q.pin;
  assign timer_match_irq = q.irq;
  assign synced_transfer_strobe = q.strobe;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence s_live_tick;
    q.run && q.count_enable_bit && tick && !q.mask;
  endsequence

  sequence s_arm_tick;
    q.run && tick && q.arm;
  endsequence

  chk_start_mask: assert property (
    q.run && tick && q.mask |=> q.cnt == '0 && !q.level && !q.mask)
    else $error("first count clock not masked");
  chk_duty_latch: assert property (
    wr && paddr == pwm_carrier_pkg::DUTY_OFS && q.run && !q.lat_pend
    |=> $stable(q.duty_compare) && q.lat_pend)
    else $error("running duty write reached active register");
  chk_duty_settle: assert property (
    q.run && $past(q.run) && $changed(q.duty_compare)
    |-> $past(q.age) == pwm_carrier_pkg::DUTY_SETTLE)
    else $error("duty transferred too early");
  chk_cycle_match: assert property (
    s_live_tick ##0 (!q.carrier && q.phase == pwm_carrier_pkg::CMP_FIRST && match)
    |=> q.cnt == '0 && q.irq && q.level)
    else $error("cycle match effects missing");
  chk_duty_match: assert property (
    s_live_tick ##0 (!q.carrier && q.phase == pwm_carrier_pkg::CMP_SECOND && match)
    |=> !q.irq && !q.level && q.cnt == CNT_W'($past(q.cnt) + 1'b1))
    else $error("duty match effects wrong");
  chk_stop_idle: assert property (
    !q.count_enable_bit && !q.carrier && !wr |=> !q.irq ##0 q.pin == q.output_level_select)
    else $error("stopped timer not inactive");
  chk_carrier_flip: assert property (
    s_live_tick ##0 (q.carrier && match)
    |=> q.cnt == '0 && q.irq && q.carrier_clk != $past(q.carrier_clk))
    else $error("carrier match did not toggle");
  chk_xfer_arm: assert property (
    q.run && tick && q.strobe |=> q.arm)
    else $error("strobe did not arm transfer");
  chk_xfer_copy: assert property (
    s_arm_tick |=> q.output_enable_active == $past(q.output_enable_buffer))
    else $error("buffer not copied to active bit");
  chk_level_out: assert property (
    q.carrier && !q.remote_control_enable && !wr |=> q.pin == q.output_enable_active)
    else $error("level output does not follow enable");
  chk_hold_high: assert property (
    q.carrier && q.remote_control_enable && q.pin && !(tick && match) && !wr &&
    q.count_enable_bit && q.run
    |=> q.pin)
    else $error("carrier high phase cut short");
  chk_restart_low: assert property (
    q.count_enable_bit && !q.run
    |=> q.phase == pwm_carrier_pkg::CMP_FIRST && !q.carrier_clk && q.mask)
    else $error("restart not from low width");
endmodule : pwm_carrier_timer
`default_nettype wire

// ### verification/gate_event_source.sv
// Behavioural model of the external gate counter's match event
`timescale 1ns/100ps
`default_nettype none
module gate_event_source #(
  parameter int HOLD = 8
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic fire,
  output logic gate_counter_match
);
  int cnt;
  // slow gate
  // Event held for many clk so the timer's count clock is well above six times its rate
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt <= 0;
    end else if (fire) begin
      cnt <= HOLD;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  assign gate_counter_match = (cnt > 0);
endmodule : gate_event_source
`default_nettype wire

// ### verification/tb_pwm_carrier_timer.sv
// Self-checking bench of the PWM and carrier timer
`timescale 1ns/100ps
`default_nettype none
module tb_pwm_carrier_timer;
  logic clk, resetn, psel, penable, pwrite, fire, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, s;
  logic pready, pslverr, gate_counter_match, timer_output_pin, timer_match_irq;
  logic synced_transfer_strobe;
  int error_cnt = 0;
  int n_tests = 0;
  int n, m, hi, lo, w;
  pwm_carrier_timer i_dut (.clk(clk), .resetn(resetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .gate_counter_match(gate_counter_match),
    .timer_output_pin(timer_output_pin), .timer_match_irq(timer_match_irq),
    .synced_transfer_strobe(synced_transfer_strobe));
  gate_event_source i_gate (.clk(clk), .resetn(resetn), .fire(fire),
    .gate_counter_match(gate_counter_match));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Outputs are read in the active region of the edge, so they still hold pre-edge values
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20) begin
      error_cnt++;
      close_out();
    end
  endtask : apb
  task automatic wait_pin(input logic lvl, output int cnt);
    cnt = 0;
    while (timer_output_pin !== lvl) begin
      @(posedge clk);
      cnt++;
      if (cnt > 3000) begin
        error_cnt++;
        close_out();
      end
    end
  endtask : wait_pin
  task automatic gate_event();
    int i;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    for (i = 0; i < 100; i++) begin
      @(posedge clk);
      if (synced_transfer_strobe === 1'b1) break;
    end
    if (i == 100) begin
      error_cnt++;
      close_out();
    end
  endtask : gate_event
  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fire = 1'b0;
    s = 32'h23C0ADDB;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    for (int a = 0; a < 5; a++) begin
      apb(1'b0, 8'(a * 4), 32'h0);
      check("reset value", rd, 32'h0);
    end
    apb(1'b0, 8'h14, 32'h0);
    check("unmapped error", {31'h0, er}, 32'h1);
    for (int k = 0; k < 3; k++) begin
      s = xs(s);
      n = 3 + s % 10;
      m = (s >> 8) % n;
      apb(1'b1, pwm_carrier_pkg::CYCLE_OFS, n);
      apb(1'b1, pwm_carrier_pkg::DUTY_OFS, m);
      apb(1'b1, pwm_carrier_pkg::MODE_OFS, 32'h1);
      wait_pin(1'b1, w);
      check("masked start", w, n + 5);
      check("irq at cycle match", {31'h0, timer_match_irq}, 32'h1);
      wait_pin(1'b0, hi);
      check("no irq at duty match", {31'h0, timer_match_irq}, 32'h0);
      wait_pin(1'b1, lo);
      check("pwm high width", hi, m + 1);
      check("pwm period", hi + lo, n + 1);
      apb(1'b1, pwm_carrier_pkg::DUTY_OFS, (m + 1) % n);
      apb(1'b0, pwm_carrier_pkg::STATUS_OFS, 32'h0);
      check("latch pending", {31'h0, rd[18]}, 32'h1);
      check("old duty active", {24'h0, rd[15:8]}, m);
      repeat (3 * n + 12) @(posedge clk);
      apb(1'b0, pwm_carrier_pkg::STATUS_OFS, 32'h0);
      check("new duty active", {24'h0, rd[15:8]}, (m + 1) % n);
      apb(1'b1, pwm_carrier_pkg::MODE_OFS, 32'h0);
      repeat (2) @(posedge clk);
      check("pin after stop", {31'h0, timer_output_pin}, 32'h0);
      check("irq after stop", {31'h0, timer_match_irq}, 32'h0);
      apb(1'b0, pwm_carrier_pkg::STATUS_OFS, 32'h0);
      check("stopped", {31'h0, rd[19]}, 32'h0);
    end
    for (int k = 0; k < 3; k++) begin
      s = xs(s);
      n = 1 + s % 8;
      m = 1 + (s >> 4) % 8;
      // low width only written while stopped
      apb(1'b1, pwm_carrier_pkg::CARRIER_OFS, (k < 2) ? 32'h5 : 32'h1);
      apb(1'b1, pwm_carrier_pkg::CYCLE_OFS, n);
      // high width rewritten on each start
      apb(1'b1, pwm_carrier_pkg::DUTY_OFS, m);
      apb(1'b1, pwm_carrier_pkg::MODE_OFS, 32'h3);
      gate_event();
      repeat (4) @(posedge clk);
      apb(1'b0, pwm_carrier_pkg::CARRIER_OFS, 32'h0);
      check("active copied", {31'h0, rd[1]}, 32'h1);
      // buffer rewrite well after the copy
      apb(1'b1, pwm_carrier_pkg::CARRIER_OFS, (k < 2) ? 32'h4 : 32'h0);
      apb(1'b0, pwm_carrier_pkg::CARRIER_OFS, 32'h0);
      check("active bit read-only", {29'h0, rd[2:0]}, (k < 2) ? 32'h6 : 32'h2);
      if (k < 2) begin
        wait_pin(1'b0, w);
        wait_pin(1'b1, w);
        check("irq at low match", {31'h0, timer_match_irq}, 32'h1);
        wait_pin(1'b0, hi);
        check("irq at high match", {31'h0, timer_match_irq}, 32'h1);
        wait_pin(1'b1, lo);
        check("carrier high", hi, m + 1);
        check("carrier low", lo, n + 1);
      end else begin
        check("steady high level", {31'h0, timer_output_pin}, 32'h1);
      end
      gate_event();
      repeat (2 * (n + m) + 12) @(posedge clk);
      check("gated off", {31'h0, timer_output_pin}, 32'h0);
      apb(1'b1, pwm_carrier_pkg::MODE_OFS, 32'h0);
      repeat (2) @(posedge clk);
      apb(1'b0, pwm_carrier_pkg::STATUS_OFS, 32'h0);
      check("carrier clock and phase reset", {30'h0, rd[17:16]}, 32'h0);
    end
    close_out();
  end
endmodule : tb_pwm_carrier_timer
`default_nettype wire
